// [verilog/timer16_pkg.sv]
// Shared constants for the 16-bit timer with input capture
package timer16_pkg;
   // ==========================================================
   // Register byte offsets on the 8-bit bus
   localparam logic [3:0] OFS_CONTROL_A       = 4'h0;
   localparam logic [3:0] OFS_CONTROL_B       = 4'h1;
   localparam logic [3:0] OFS_COUNT_LOW       = 4'h2;
   localparam logic [3:0] OFS_COUNT_HIGH      = 4'h3;
   localparam logic [3:0] OFS_CAPTURE_LOW     = 4'h4;
   localparam logic [3:0] OFS_CAPTURE_HIGH    = 4'h5;
   localparam logic [3:0] OFS_FLAGS           = 4'h6;
   localparam logic [3:0] OFS_IRQ_MASK        = 4'h7;
   localparam logic [3:0] OFS_COMPARATOR_CTRL = 4'h8;
   // ==========================================================
   // Field positions
   localparam int CS_LSB       = 0;  // clock_source_select [2:0] in control B
   localparam int WGM_HI_LSB   = 3;  // waveform_mode_select [3:2] in control B
   localparam int EDGE_BIT     = 6;  // capture edge, 1 = rising
   localparam int FILTER_BIT   = 7;  // capture_filter_enable
   localparam int WGM_LO_LSB   = 0;  // waveform_mode_select [1:0] in control A
   localparam int OVF_BIT      = 0;  // overflow flag / enable
   localparam int CAP_BIT      = 5;  // capture flag / enable
   localparam int CMP_SEL_BIT  = 2;  // comparator_capture_select
   // ==========================================================
   // Reset values
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [9:0]  RST_PRE   = 10'h000;
   // ==========================================================
   // Clock select codes
   localparam logic [2:0] CS_STOP   = 3'h0;
   localparam logic [2:0] CS_DIV1   = 3'h1;
   localparam logic [2:0] CS_DIV8   = 3'h2;
   localparam logic [2:0] CS_DIV64  = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1K  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   // ==========================================================
   // Fixed TOP values and counter limits
   localparam logic [15:0] TOP_8BIT  = 16'h00ff;
   localparam logic [15:0] TOP_9BIT  = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_MIN = 16'h0000;
   // ==========================================================
   // Sampling chain lengths in system clocks
   localparam int SYNC_STAGES  = 3;
   localparam int FILTER_TAPS  = 4;
endpackage : timer16_pkg

// [verilog/pin_sampler.sv]
// Three-stage pin synchroniser with optional four-sample noise filter
`timescale 1ns/100ps
module pin_sampler
#(
   parameter int TAPS = timer16_pkg::FILTER_TAPS
)
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic pin_raw,
   input  wire logic filter_en,
   output logic      level
);
   import timer16_pkg::*;

   logic [SYNC_STAGES-1:0] sync;
   logic                   stable;
   logic [TAPS-1:0]        taps;
   logic                   filtered;
   logic                   next_level;

   // ==========================================================
   // Synchroniser, change counts once stages two and three agree
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         sync <= '0;
      else
         sync <= {sync[SYNC_STAGES-2:0], pin_raw};
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         stable <= 1'b0;
      else if (sync[1] == sync[2])
         stable <= sync[2];
   end

   // ==========================================================
   // Filter changes only when every tap holds the new level
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         taps     <= '0;
         filtered <= 1'b0;
      end
      else
      begin
         taps <= {taps[TAPS-2:0], stable};
         if (&taps)
            filtered <= 1'b1;
         else if (~|taps)
            filtered <= 1'b0;
      end
   end

   // Filter bypass select
   assign next_level = filter_en ? filtered : stable;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         level <= 1'b0;
      else
         level <= next_level;
   end
endmodule : pin_sampler

// [verilog/timer16_capture.sv]
// 16-bit timer/counter with input capture behind an Avalon-MM slave
`timescale 1ns/100ps
module timer16_capture
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [7:0]  avs_writedata,
   output logic [7:0]       avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        external_count_pin,
   input  wire logic        capture_input_pin,
   input  wire logic        comparator_result_out,
   input  wire logic [15:0] compare_a_value,
   input  wire logic        overflow_irq_ack,
   input  wire logic        capture_irq_ack,
   output logic [15:0]      timer_count_value,
   output logic             timer_tick,
   output logic             timer_top,
   output logic             timer_bottom,
   output logic             overflow_irq,
   output logic             capture_irq
);
   import timer16_pkg::*;

   // ==========================================================
   // Mode decoding helpers
   function automatic logic [15:0] top_of(input logic [3:0] m,
                                          input logic [15:0] icr,
                                          input logic [15:0] ocr);
      unique case (m)
         4'h1, 4'h5:                top_of = TOP_8BIT;
         4'h2, 4'h6:                top_of = TOP_9BIT;
         4'h3, 4'h7:                top_of = TOP_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf:    top_of = ocr;
         4'h8, 4'ha, 4'hc, 4'he:    top_of = icr;
         default:                   top_of = COUNT_MAX;
      endcase
   endfunction : top_of

   function automatic logic uses_icr(input logic [3:0] m);
      uses_icr = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
   endfunction : uses_icr

   function automatic logic dual_slope(input logic [3:0] m);
      dual_slope = (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
   endfunction : dual_slope

   function automatic logic ovf_at_top(input logic [3:0] m);
      ovf_at_top = (m inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf});
   endfunction : ovf_at_top

   // ==========================================================
   // Registers
   logic [7:0]  control_a;
   logic [7:0]  control_b;
   logic [7:0]  irq_mask;
   logic [7:0]  comparator_control_status;
   logic [7:0]  temp_high;
   logic [15:0] capture_value_reg;
   logic        counter_overflow_flag;
   logic        capture_event_flag;
   logic        count_down;
   logic [9:0]  prescale;
   logic        ext_prev;
   logic        cap_prev;

   // ==========================================================
   // Decoded fields and bus strobes
   wire  [2:0]  clock_source_select   = control_b[CS_LSB +: 3];
   wire  [3:0]  waveform_mode_select  = {control_b[WGM_HI_LSB +: 2],
                                         control_a[WGM_LO_LSB +: 2]};
   wire         capture_filter_enable = control_b[FILTER_BIT];
   wire         capture_rising        = control_b[EDGE_BIT];
   wire         comparator_capture_select = comparator_control_status[CMP_SEL_BIT];
   wire         bus_req    = avs_read | avs_write;
   wire         read_take  = avs_read & avs_waitrequest;
   wire         write_do   = avs_write & ~avs_waitrequest;
   wire         wr_ctrl_a  = write_do && (avs_address == OFS_CONTROL_A);
   wire         wr_ctrl_b  = write_do && (avs_address == OFS_CONTROL_B);
   wire         wr_cnt_lo  = write_do && (avs_address == OFS_COUNT_LOW);
   wire         wr_cap_lo  = write_do && (avs_address == OFS_CAPTURE_LOW);
   wire         wr_flags   = write_do && (avs_address == OFS_FLAGS);
   wire         wr_mask    = write_do && (avs_address == OFS_IRQ_MASK);
   wire         wr_cmp     = write_do && (avs_address == OFS_COMPARATOR_CTRL);
   wire         wr_high    = write_do && ((avs_address == OFS_COUNT_HIGH) ||
                                          (avs_address == OFS_CAPTURE_HIGH));
   wire         rd_cnt_lo  = read_take && (avs_address == OFS_COUNT_LOW);
   wire         rd_cap_lo  = read_take && (avs_address == OFS_CAPTURE_LOW);

   // Mode properties of the current setting
   wire         icr_top    = uses_icr(waveform_mode_select);
   wire         slope2     = dual_slope(waveform_mode_select);
   wire  [15:0] top_value  = top_of(waveform_mode_select, capture_value_reg,
                                    compare_a_value);
   wire         at_top     = (timer_count_value == top_value);
   wire         at_bottom  = (timer_count_value == COUNT_MIN);
   wire         at_max     = (timer_count_value == COUNT_MAX);

   // ==========================================================
   // Sampled pins
   logic ext_level;
   logic cap_level;
   wire  cap_source = comparator_capture_select ? comparator_result_out
                                                : capture_input_pin;

   pin_sampler #(.TAPS(FILTER_TAPS)) ext_sampler
   (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .pin_raw   (external_count_pin),
      .filter_en (1'b0),
      .level     (ext_level)
   );

   // Same sampling as the count pin, filter adds five clocks
   pin_sampler #(.TAPS(FILTER_TAPS)) cap_sampler
   (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .pin_raw   (cap_source),
      .filter_en (capture_filter_enable),
      .level     (cap_level)
   );

   // ==========================================================
   // Timer tick selection
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         prescale <= RST_PRE;
         ext_prev <= 1'b0;
      end
      else
      begin
         prescale <= prescale + 10'h001;
         ext_prev <= ext_level;
      end
   end

   logic next_tick;
   wire  ext_rise = ext_level & ~ext_prev;
   wire  ext_fall = ~ext_level & ext_prev;

   // Prescaler taps and external edges
   always_comb
   begin
      unique case (clock_source_select)
         CS_STOP:     next_tick = 1'b0;
         CS_DIV1:     next_tick = 1'b1;
         CS_DIV8:     next_tick = &prescale[2:0];
         CS_DIV64:    next_tick = &prescale[5:0];
         CS_DIV256:   next_tick = &prescale[7:0];
         CS_DIV1K:    next_tick = &prescale[9:0];
         CS_EXT_FALL: next_tick = ext_fall;
         CS_EXT_RISE: next_tick = ext_rise;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         timer_tick <= 1'b0;
      else
         timer_tick <= next_tick;
   end

   // ==========================================================
   // Counter next value
   logic [15:0] next_count;
   logic        next_down;
   logic        ovf_event;

   always_comb
   begin
      next_count = timer_count_value;
      next_down  = count_down;
      ovf_event  = 1'b0;
      if (wr_cnt_lo)
         next_count = {temp_high, avs_writedata};
      else if (timer_tick && slope2)
      begin
         if (at_bottom)
         begin
            next_down  = 1'b0;
            next_count = timer_count_value + 16'h0001;
            ovf_event  = count_down;
         end
         else if (at_top || !count_down && timer_count_value > top_value)
         begin
            next_down  = 1'b1;
            next_count = timer_count_value - 16'h0001;
         end
         else if (count_down)
            next_count = timer_count_value - 16'h0001;
         else
            next_count = timer_count_value + 16'h0001;
      end
      else if (timer_tick)
      begin
         next_down  = 1'b0;
         if (at_top)
            next_count = COUNT_MIN;
         else
            next_count = timer_count_value + 16'h0001;
         ovf_event = ovf_at_top(waveform_mode_select) ? at_top : at_max;
      end
   end

   // Counter, direction and extreme indications
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         timer_count_value <= RST_WORD;
         count_down        <= 1'b0;
         timer_top         <= 1'b0;
         timer_bottom      <= 1'b1;
      end
      else
      begin
         timer_count_value <= next_count;
         count_down        <= next_down;
         timer_top         <= (next_count == top_value);
         timer_bottom      <= (next_count == COUNT_MIN);
      end
   end

   // ==========================================================
   // Capture edge detector
   logic capture_trigger;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cap_prev <= 1'b0;
      else
         cap_prev <= cap_level;
   end

   assign capture_trigger = (cap_level != cap_prev) &&
                            (cap_level == capture_rising) &&
                            !icr_top;

   // Capture register: event copy or write in capture-top modes
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         capture_value_reg <= RST_WORD;
      else if (capture_trigger)
         capture_value_reg <= timer_count_value;
      else if (wr_cap_lo && icr_top)
         capture_value_reg <= {temp_high, avs_writedata};
   end

   // ==========================================================
   // Shared high byte temporary register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         temp_high <= RST_BYTE;
      else if (wr_high)
         temp_high <= avs_writedata;
      else if (rd_cnt_lo)
         temp_high <= timer_count_value[15:8];
      else if (rd_cap_lo)
         temp_high <= capture_value_reg[15:8];
   end

   // ==========================================================
   // Event flags, set wins over any clear
   wire clr_ovf = (wr_flags && avs_writedata[OVF_BIT]) || overflow_irq_ack;
   wire clr_cap = (wr_flags && avs_writedata[CAP_BIT]) || capture_irq_ack;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         counter_overflow_flag <= 1'b0;
         capture_event_flag    <= 1'b0;
      end
      else
      begin
         counter_overflow_flag <= ovf_event | (counter_overflow_flag & ~clr_ovf);
         capture_event_flag    <= capture_trigger |
                                  (capture_event_flag & ~clr_cap);
      end
   end

   // Interrupt requests from flags and enables
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         overflow_irq <= 1'b0;
         capture_irq  <= 1'b0;
      end
      else
      begin
         overflow_irq <= counter_overflow_flag & irq_mask[OVF_BIT];
         capture_irq  <= capture_event_flag & irq_mask[CAP_BIT];
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         control_a                 <= RST_BYTE;
         control_b                 <= RST_BYTE;
         irq_mask                  <= RST_BYTE;
         comparator_control_status <= RST_BYTE;
      end
      else
      begin
         if (wr_ctrl_a)
            control_a <= avs_writedata;
         if (wr_ctrl_b)
            control_b <= avs_writedata;
         if (wr_mask)
            irq_mask <= avs_writedata;
         if (wr_cmp)
            comparator_control_status <= avs_writedata;
      end
   end

   // ==========================================================
   // Read data selection
   logic [7:0] read_mux;
   wire  [7:0] flags_view = (8'h01 << OVF_BIT) & {8{counter_overflow_flag}} |
                            (8'h01 << CAP_BIT) & {8{capture_event_flag}};

   assign read_mux =
      (avs_address == OFS_CONTROL_A)       ? control_a :
      (avs_address == OFS_CONTROL_B)       ? control_b :
      (avs_address == OFS_COUNT_LOW)       ? timer_count_value[7:0] :
      (avs_address == OFS_COUNT_HIGH)      ? temp_high :
      (avs_address == OFS_CAPTURE_LOW)     ? capture_value_reg[7:0] :
      (avs_address == OFS_CAPTURE_HIGH)    ? temp_high :
      (avs_address == OFS_FLAGS)           ? flags_view :
      (avs_address == OFS_IRQ_MASK)        ? irq_mask :
      (avs_address == OFS_COMPARATOR_CTRL) ? comparator_control_status :
                                             RST_BYTE;

   // ==========================================================
   // Bus handshake: one wait cycle, then answer
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= RST_BYTE;
      end
      else
      begin
         avs_waitrequest <= ~(bus_req & avs_waitrequest);
         if (read_take)
            avs_readdata <= read_mux;
      end
   end
endmodule : timer16_capture

// [testbench/timer16_capture_props.sv]
// Port checker for the 16-bit timer with input capture
`timescale 1ns/100ps
module timer16_capture_props
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [7:0]  avs_writedata,
   input wire logic [7:0]  avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [15:0] timer_count_value,
   input wire logic        timer_tick,
   input wire logic        timer_bottom,
   input wire logic        overflow_irq_ack,
   input wire logic        capture_irq_ack,
   input wire logic        overflow_irq,
   input wire logic        capture_irq
);
   import timer16_pkg::*;
   // ====
   // Bus and counter relations
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_wait_once: assert property (
      ($rose(avs_read) || $rose(avs_write)) |=> !avs_waitrequest)
      else $error("bus answer late");
   a_wait_single: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer too long");
   a_bottom_zero: assert property (
      $stable(timer_count_value) |-> timer_bottom == (timer_count_value == COUNT_MIN))
      else $error("bottom flag wrong");
   a_count_step: assert property (
      timer_tick && !avs_write |=> timer_count_value == $past(timer_count_value) + 16'h1
      || timer_count_value == $past(timer_count_value) - 16'h1 || timer_count_value == 16'h0)
      else $error("count step wrong");
   a_count_hold: assert property (
      !timer_tick && !avs_write |=> $stable(timer_count_value))
      else $error("count moved without tick");
   a_write_wins: assert property (
      avs_write && !avs_waitrequest && avs_address == OFS_COUNT_LOW
      |=> timer_count_value[7:0] == $past(avs_writedata))
      else $error("count write lost");
   a_ovf_ack: assert property (
      overflow_irq_ack |-> ##2 !overflow_irq)
      else $error("overflow ack ignored");
   a_cap_ack: assert property (
      capture_irq_ack |-> ##2 !capture_irq)
      else $error("capture ack ignored");
   // Main scenarios reached
   c_cap: cover property (capture_irq);
   c_ovf: cover property (overflow_irq);
   c_tick: cover property (timer_tick);
endmodule : timer16_capture_props
bind timer16_capture timer16_capture_props u_props (.clk, .sys_rst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .timer_count_value,
   .timer_tick, .timer_bottom, .overflow_irq_ack, .capture_irq_ack, .overflow_irq,
   .capture_irq);

// [testbench/cpu_bus_model.sv]
// CPU side bus master model
`timescale 1ns/100ps
module cpu_bus_model
(
   input  wire logic       clk,
   output logic [3:0]      avs_address,
   output logic            avs_read,
   output logic            avs_write,
   output logic [7:0]      avs_writedata,
   input  wire logic [7:0] avs_readdata,
   input  wire logic       avs_waitrequest,
   output logic            hung
);
   // ====
   // Idle bus at time zero
   initial
   begin
      {avs_address, avs_read, avs_write, avs_writedata, hung} = '0;
   end
   // Hold request until waitrequest low at an edge
   task automatic wait_ack;
      int n;
      n = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50)
      begin
         n++;
         @(posedge clk);
      end
      if (n >= 50) hung <= 1'b1;
   endtask : wait_ack
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : rd
   // High location first so temp holds it when low commits
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      wr(lo + 4'h1, v[15:8]);
      wr(lo, v[7:0]);
   endtask : wr16
   // Low first loads temp with the matching high byte
   task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 4'h1, v[15:8]);
   endtask : rd16
endmodule : cpu_bus_model

// [testbench/timer16_capture_tb.sv]
// Self-checking bench for the 16-bit timer with input capture
`timescale 1ns/100ps
module timer16_capture_tb;
   import timer16_pkg::*;
   logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, hung, external_count_pin;
   logic capture_input_pin, comparator_result_out, overflow_irq_ack, capture_irq_ack;
   logic timer_tick, timer_top, timer_bottom, overflow_irq, capture_irq;
   logic [3:0]  avs_address;
   logic [7:0]  avs_writedata, avs_readdata, b;
   logic [15:0] compare_a_value, timer_count_value, v;
   int          err_count, checked;
   timer16_capture DUT (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .external_count_pin, .capture_input_pin,
      .comparator_result_out, .compare_a_value, .overflow_irq_ack, .capture_irq_ack,
      .timer_count_value, .timer_tick, .timer_top, .timer_bottom, .overflow_irq, .capture_irq);
   cpu_bus_model cpu (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .hung);
   // ====
   // Helpers
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic finish_test;
      if (err_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic pin(input logic p, input int n);
      capture_input_pin <= p;
      repeat (n) @(posedge clk);
   endtask : pin
   task automatic flag(input logic e);
      cpu.rd(OFS_FLAGS, b);
      chk("capture flag", {15'h0000, b[5]}, {15'h0000, e});
   endtask : flag
   task automatic ack(input logic ovf);
      overflow_irq_ack <= ovf;
      capture_irq_ack <= !ovf;
      @(posedge clk);
      {overflow_irq_ack, capture_irq_ack} <= 2'b00;
      repeat (3) @(posedge clk);
   endtask : ack
   always @(posedge hung)
   begin
      err_count++;
      finish_test();
   end
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ====
   // Main sequence
   initial
   begin
      {sys_rst, capture_input_pin, comparator_result_out, external_count_pin} = 4'b1000;
      {overflow_irq_ack, capture_irq_ack} = 2'b00;
      compare_a_value = 16'h0005;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      cpu.rd16(OFS_COUNT_LOW, v);
      chk("count", v, 16'h0000);
      chk("bottom", {15'h0000, timer_bottom}, 16'h0001);
      cpu.wr16(OFS_COUNT_LOW, 16'h1234);
      cpu.rd16(OFS_COUNT_LOW, v);
      chk("count", v, 16'h1234);
      cpu.wr(OFS_COUNT_HIGH, 8'ha5);
      cpu.rd(OFS_COUNT_HIGH, b);
      chk("temp", {8'h00, b}, 16'h00a5);
      cpu.rd(4'h9, b);
      chk("unmapped", {8'h00, b}, 16'h0000);
      // Wrap past MAX at full rate
      cpu.wr16(OFS_COUNT_LOW, 16'hfff0);
      cpu.wr(OFS_IRQ_MASK, 8'h01);
      cpu.wr(OFS_CONTROL_B, {5'h00, CS_DIV1});
      repeat (20) @(posedge clk);
      cpu.wr(OFS_CONTROL_B, 8'h00);
      cpu.rd16(OFS_COUNT_LOW, v);
      chk("count high", {8'h00, v[15:8]}, 16'h0000);
      chk("ovf irq", {15'h0000, overflow_irq}, 16'h0001);
      ack(1'b1);
      chk("ovf irq", {15'h0000, overflow_irq}, 16'h0000);
      // Clear on compare A, mode 4
      cpu.wr16(OFS_COUNT_LOW, 16'h0000);
      cpu.wr(OFS_CONTROL_B, 8'h09);
      repeat (40) @(posedge clk);
      cpu.wr(OFS_CONTROL_B, 8'h08);
      cpu.rd16(OFS_COUNT_LOW, v);
      chk("ctc bound", {15'h0000, v > 16'h0005}, 16'h0000);
      cpu.wr16(OFS_COUNT_LOW, 16'h0005);
      chk("top", {15'h0000, timer_top}, 16'h0001);
      chk("bottom", {15'h0000, timer_bottom}, 16'h0000);
      // External rising edges, three counts
      cpu.wr16(OFS_COUNT_LOW, 16'h0000);
      cpu.wr(OFS_CONTROL_B, {5'h00, CS_EXT_RISE});
      repeat (3)
      begin
         external_count_pin <= 1'b1;
         repeat (8) @(posedge clk);
         external_count_pin <= 1'b0;
         repeat (8) @(posedge clk);
      end
      cpu.wr(OFS_CONTROL_B, 8'h00);
      cpu.rd16(OFS_COUNT_LOW, v);
      chk("ext count", v, 16'h0003);
      // Dual slope mode 1, eight ticks turn at TOP 0x00ff
      cpu.wr(OFS_CONTROL_A, 8'h01);
      cpu.wr16(OFS_COUNT_LOW, 16'h00fa);
      cpu.wr(OFS_CONTROL_B, {5'h00, CS_DIV1});
      repeat (5) @(posedge clk);
      cpu.wr(OFS_CONTROL_B, 8'h00);
      cpu.rd16(OFS_COUNT_LOW, v);
      chk("dual slope", v, 16'h00fc);
      cpu.wr(OFS_CONTROL_A, 8'h00);
      // Rising edge capture, flag clear by writing one
      cpu.wr16(OFS_COUNT_LOW, 16'h1234);
      cpu.wr(OFS_CONTROL_B, 8'h40);
      cpu.wr(OFS_FLAGS, 8'h21);
      cpu.wr(OFS_IRQ_MASK, 8'h20);
      pin(1'b1, 16);
      chk("cap irq", {15'h0000, capture_irq}, 16'h0001);
      cpu.wr(OFS_FLAGS, 8'h20);
      flag(1'b0);
      pin(1'b0, 16);
      flag(1'b0);
      cpu.wr16(OFS_COUNT_LOW, 16'h5678);
      pin(1'b1, 16);
      flag(1'b1);
      ack(1'b0);
      chk("cap irq", {15'h0000, capture_irq}, 16'h0000);
      cpu.rd16(OFS_CAPTURE_LOW, v);
      chk("capture", v, 16'h5678);
      // Filter rejects a three-cycle glitch
      cpu.wr(OFS_CONTROL_B, 8'hc0);
      pin(1'b0, 16);
      cpu.wr(OFS_FLAGS, 8'h20);
      pin(1'b1, 3);
      pin(1'b0, 16);
      flag(1'b0);
      pin(1'b1, 20);
      flag(1'b1);
      // Comparator as source, flag cleared after switching
      cpu.wr(OFS_COMPARATOR_CTRL, 8'h04);
      cpu.wr(OFS_FLAGS, 8'h20);
      repeat (16) @(posedge clk);
      comparator_result_out <= 1'b1;
      repeat (20) @(posedge clk);
      flag(1'b1);
      // Capture writes only in capture-as-TOP modes
      cpu.wr16(OFS_CAPTURE_LOW, 16'habcd);
      cpu.rd16(OFS_CAPTURE_LOW, v);
      chk("capture", v, 16'h5678);
      cpu.wr(OFS_CONTROL_B, 8'h18);
      cpu.wr16(OFS_CAPTURE_LOW, 16'habcd);
      cpu.rd16(OFS_CAPTURE_LOW, v);
      chk("capture", v, 16'habcd);
      finish_test();
   end
endmodule : timer16_capture_tb
